// file: logic/irhc_top.sv
/*
 * Hold-off prescaler and counter, and per-input re-validation counters,
 * with an Avalon-MM register slave and one level interrupt.
 * Assumes vcxo_clk_in and ref_clk_in are already synchronous to sys_clk
 * and slower than half its rate; los_event comes from the LOS detectors.
 */
// Operation
// - Prescale VCXO by 2^15, 2^16 or 2^17
// - Each valid reference period decrements counter
// - Missing edges for a period reload count
// - Counter reaching zero clears the loss flag
// - Select codes give 2, 16, 32, 64 periods
// - Hold-off counts after LOS, failover at zero
// - Hold-off reloads from period after zero
// - Hold-off period 8 bits, resets to 0x80
`include "irhc_consts.svh"

module irhc_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire irhc_pkg::irhc_word_t avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output irhc_pkg::irhc_word_t avs_readdata,
	output logic avs_waitrequest,
	input wire logic vcxo_clk_in,
	input wire logic [1:0] ref_clk_in,
	input wire logic [1:0] los_event,
	output logic [1:0] los_flag,
	output logic failover_start,
	output logic irq
);
	import irhc_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic waitrequest_reg;
	logic [1:0] prescale_select_reg;
	logic [1:0] revalidation_count_select_reg;
	logic hold_en_reg;
	logic [7:0] holdoff_period_reg;
	logic [15:0] miss_limit_reg;
	logic [2:0] irq_stat_reg;
	logic [2:0] irq_mask_reg;
	irhc_word_t readdata_reg;
	logic [7:0] holdoff_cnt_reg;
	logic [16:0] pre_cnt_reg;
	logic vcxo_q_reg;
	logic [1:0] los_reg;
	logic failover_reg;
	logic pre_tick;
	logic holdoff_zero;
	logic [1:0] reval_done;
	logic bus_req;
	logic bus_go;
	logic [16:0] pre_mask;
	irhc_rev_cnt_t rev_start;

	assign bus_req = avs_read | avs_write;
	// Access completes on the edge where waitrequest is low
	assign bus_go = bus_req & ~waitrequest_reg;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= ~(bus_req & waitrequest_reg);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control register, written only on the completing edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			prescale_select_reg <= `IRHC_PRE_RESET;
			revalidation_count_select_reg <= `IRHC_REV_RESET;
			hold_en_reg <= 1'b0;
			holdoff_period_reg <= `IRHC_PER_RESET;
		end else if (bus_go && avs_write &&
				avs_address == `IRHC_ADDR_CTRL) begin
			if (avs_byteenable[0]) begin
				prescale_select_reg <=
					avs_writedata[`IRHC_CTRL_PRE_LSB +: 2];
				revalidation_count_select_reg <=
					avs_writedata[`IRHC_CTRL_REV_LSB +: 2];
				hold_en_reg <= avs_writedata[`IRHC_CTRL_HOLD_EN];
			end
			if (avs_byteenable[1]) begin
				holdoff_period_reg <=
					avs_writedata[`IRHC_CTRL_PER_LSB +: 8];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			miss_limit_reg <= `IRHC_MISS_RESET;
		end else if (bus_go && avs_write &&
				avs_address == `IRHC_ADDR_MISS_LIM) begin
			if (avs_byteenable[0]) begin
				miss_limit_reg[7:0] <= avs_writedata[7:0];
			end
			if (avs_byteenable[1]) begin
				miss_limit_reg[15:8] <= avs_writedata[15:8];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_mask_reg <= 3'h0;
		end else if (bus_go && avs_write && avs_byteenable[0] &&
				avs_address == `IRHC_ADDR_IRQ_MASK) begin
			irq_mask_reg <= avs_writedata[2:0];
		end
	end

	// Sticky events; a new event wins over a write-one clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_stat_reg <= 3'h0;
		end else begin
			irq_stat_reg <= (irq_stat_reg &
				~((bus_go && avs_write && avs_byteenable[0] &&
				avs_address == `IRHC_ADDR_IRQ_STAT) ?
				avs_writedata[2:0] : 3'h0)) |
				{reval_done, failover_reg};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Read data latched on the edge that drops waitrequest
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			readdata_reg <= 32'h0000_0000;
		end else if (avs_read && waitrequest_reg) begin
			unique case (avs_address)
			`IRHC_ADDR_CTRL: readdata_reg <= {16'h0000,
				holdoff_period_reg, 3'h0, hold_en_reg,
				revalidation_count_select_reg, prescale_select_reg};
			`IRHC_ADDR_STATUS: readdata_reg <= {16'h0000,
				holdoff_cnt_reg, 6'h00, los_reg};
			`IRHC_ADDR_IRQ_STAT: readdata_reg <= {29'h0, irq_stat_reg};
			`IRHC_ADDR_IRQ_MASK: readdata_reg <= {29'h0, irq_mask_reg};
			`IRHC_ADDR_MISS_LIM: readdata_reg <= {16'h0000,
				miss_limit_reg};
			// Unmapped addresses answer with zero
			default: readdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Prescaler counts VCXO rising edges
	always_comb begin
		unique case (prescale_select_reg)
		2'h0: pre_mask = `IRHC_PRE_MASK_0;
		2'h1: pre_mask = `IRHC_PRE_MASK_1;
		// Code 11 is reserved; treated as the slowest division
		default: pre_mask = `IRHC_PRE_MASK_2;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			vcxo_q_reg <= 1'b0;
			pre_cnt_reg <= 17'h0_0000;
		end else begin
			vcxo_q_reg <= vcxo_clk_in;
			if (vcxo_clk_in && !vcxo_q_reg) begin
				pre_cnt_reg <= pre_tick ? 17'h0_0000 :
					pre_cnt_reg + 17'h0_0001;
			end
		end
	end

	assign pre_tick = vcxo_clk_in & ~vcxo_q_reg &
		((pre_cnt_reg & pre_mask) == pre_mask);

	// Hold-off counter idles loaded until a loss is pending with hold-off enabled
	// Period zero fires once per tick, never on every cycle
	assign holdoff_zero = pre_tick && holdoff_cnt_reg <= 8'h01;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			holdoff_cnt_reg <= `IRHC_PER_RESET;
			failover_reg <= 1'b0;
		end else begin
			failover_reg <= 1'b0;
			if (!(hold_en_reg && |los_reg)) begin
				holdoff_cnt_reg <= holdoff_period_reg;
			end else if (holdoff_zero) begin
				holdoff_cnt_reg <= holdoff_period_reg;
				failover_reg <= 1'b1;
			end else if (pre_tick) begin
				holdoff_cnt_reg <= holdoff_cnt_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			failover_start <= 1'b0;
			los_flag <= 2'h0;
			avs_waitrequest <= 1'b1;
		end else begin
			failover_start <= failover_reg;
			los_flag <= los_reg;
			avs_waitrequest <= ~(bus_req & waitrequest_reg);
		end
	end

	assign avs_readdata = readdata_reg;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		unique case (revalidation_count_select_reg)
		2'h0: rev_start = `IRHC_REV_CNT_0;
		2'h1: rev_start = `IRHC_REV_CNT_1;
		2'h2: rev_start = `IRHC_REV_CNT_2;
		2'h3: rev_start = `IRHC_REV_CNT_3;
		endcase
	end

	generate
		for (genvar i = 0; i < 2; i++) begin : g_ch
			irhc_rev_cnt_t rev_cnt_reg;
			logic [15:0] miss_cnt_reg;
			logic ref_q_reg;
			logic lost_reg;
			logic edge_seen;
			logic missed;

			assign los_reg[i] = lost_reg;
			assign edge_seen = ref_clk_in[i] & ~ref_q_reg;
			// A period with no edge inside the window counts as missed
			assign missed = !edge_seen && miss_cnt_reg >= miss_limit_reg;
			assign reval_done[i] = los_reg[i] && !los_event[i] &&
				!missed && edge_seen && rev_cnt_reg == 7'h01;

			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					ref_q_reg <= 1'b0;
					miss_cnt_reg <= 16'h0000;
				end else begin
					ref_q_reg <= ref_clk_in[i];
					miss_cnt_reg <= (edge_seen || missed) ? 16'h0000 :
						miss_cnt_reg + 16'h0001;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					rev_cnt_reg <= 7'h00;
					lost_reg <= 1'b0;
				end else if (los_event[i]) begin
					rev_cnt_reg <= rev_start;
					lost_reg <= 1'b1;
				end else if (los_reg[i]) begin
					if (missed) begin
						rev_cnt_reg <= rev_start;
					end else if (reval_done[i]) begin
						rev_cnt_reg <= 7'h00;
						lost_reg <= 1'b0;
					end else if (edge_seen) begin
						rev_cnt_reg <= rev_cnt_reg - 7'h01;
					end
				end
			end
		end
	endgenerate
endmodule : irhc_top

// file: logic/irhc_consts.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * input re-validation and hold-off counter block.
 * Assumes byte addresses on a 32-bit Avalon-MM register bus.
 */
`ifndef IRHC_CONSTS_SVH
`define IRHC_CONSTS_SVH

`define IRHC_ADDR_CTRL 8'h00
`define IRHC_ADDR_STATUS 8'h04
`define IRHC_ADDR_IRQ_STAT 8'h08
`define IRHC_ADDR_IRQ_MASK 8'h0C
`define IRHC_ADDR_MISS_LIM 8'h10

`define IRHC_CTRL_PRE_LSB 0
`define IRHC_CTRL_REV_LSB 2
`define IRHC_CTRL_HOLD_EN 4
`define IRHC_CTRL_PER_LSB 8

`define IRHC_PRE_RESET 2'h2
`define IRHC_REV_RESET 2'h2
`define IRHC_PER_RESET 8'h80
`define IRHC_MISS_RESET 16'h0100

`define IRHC_REV_CNT_0 7'h02
`define IRHC_REV_CNT_1 7'h10
`define IRHC_REV_CNT_2 7'h20
`define IRHC_REV_CNT_3 7'h40

`define IRHC_PRE_MASK_0 17'h0_7FFF
`define IRHC_PRE_MASK_1 17'h0_FFFF
`define IRHC_PRE_MASK_2 17'h1_FFFF

`define IRHC_IRQ_FAILOVER 0
`define IRHC_IRQ_REVAL_LSB 1

`endif

// file: logic/irhc_pkg.sv
/*
 * Types shared by the re-validation and hold-off counter block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package irhc_pkg;
	typedef logic [1:0] irhc_sel_t;
	typedef logic [6:0] irhc_rev_cnt_t;
	typedef logic [31:0] irhc_word_t;
endpackage : irhc_pkg

// file: verif/irhc_asserts.sv
/* Port checker for irhc_top: bus handshake, loss flags, failover pulse.
 Assumes it is bound into irhc_top and sees one clock domain. */
module irhc_asserts (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [1:0] ref_clk_in,
	input wire logic [1:0] los_event,
	input wire logic [1:0] los_flag,
	input wire logic failover_start
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_ack;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("no bus answer");
	property p_one;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_one: assert property (p_one) else $error("answer too long");
	property p_idle;
		!avs_read && !avs_write |=> avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");
	property p_set0;
		los_event[0] |-> ##2 los_flag[0];
	endproperty
	a_set0: assert property (p_set0) else $error("flag 0 not set");
	property p_set1;
		los_event[1] |-> ##2 los_flag[1];
	endproperty
	a_set1: assert property (p_set1) else $error("flag 1 not set");
	property p_cause;
		$rose(los_flag[0]) |-> $past(los_event[0], 2);
	endproperty
	a_cause: assert property (p_cause) else $error("flag without loss");
	// Two periods minimum, so a flag never lasts a single cycle
	property p_hold;
		$rose(los_flag[0]) |=> los_flag[0][*2];
	endproperty
	a_hold: assert property (p_hold) else $error("flag too short");
	property p_clr;
		$fell(los_flag[0]) && !$past(sys_rst) |->
			$past(ref_clk_in[0], 2) && !$past(ref_clk_in[0], 3);
	endproperty
	a_clr: assert property (p_clr) else $error("clear off edge");
	property p_fo;
		failover_start |=> !failover_start;
	endproperty
	a_fo: assert property (p_fo) else $error("failover not a pulse");
	c_fo: cover property (failover_start);
	c_clr: cover property ($fell(los_flag[0]));
	c_rd: cover property (avs_read && !avs_waitrequest);
endmodule : irhc_asserts

bind irhc_top irhc_asserts u_irhc_asserts (.sys_clk, .sys_rst, .avs_read,
	.avs_write, .avs_waitrequest, .ref_clk_in, .los_event, .los_flag,
	.failover_start);

// file: verif/irhc_ref_model.sv
/* Source of the two monitored reference inputs.
 Assumes the bench calls burst() from its own process after a clock edge. */
module irhc_ref_model (
	input wire logic sys_clk,
	output logic [1:0] ref_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	initial ref_clk = 2'h0;
	// A lost input sits flat, as a dead oscillator would
	task automatic burst(input int i, input int n, input int gap);
		repeat (n) begin
			@(posedge sys_clk) ref_clk[i] <= 1'b1;
			repeat (gap) @(posedge sys_clk);
			ref_clk[i] <= 1'b0;
			repeat (gap) @(posedge sys_clk);
		end
	endtask : burst
endmodule : irhc_ref_model

// file: verif/input_revalidation_holdoff_counters_tb_top.sv
/* Bench for irhc_top: registers, re-validation, interrupt, failover.
 Assumes irhc_ref_model drives the reference inputs. */
`include "irhc_consts.svh"
module input_revalidation_holdoff_counters_tb_top
	import irhc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
	logic vcxo_clk_in = 0, avs_waitrequest, failover_start, irq;
	logic [7:0] avs_address = '0;
	logic [3:0] avs_byteenable = 4'h3;
	logic [1:0] ref_clk_in, los_flag, los_event = '0;
	irhc_word_t avs_writedata = '0, avs_readdata;
	logic [31:0] seed = 32'h0000_f450;
	logic [32:0] exp_q[$];
	int fail_count = 0, samples_checked = 0, t, n;
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) vcxo_clk_in <= ~vcxo_clk_in;
	irhc_top u_irhc_top (.sys_clk, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .vcxo_clk_in, .ref_clk_in, .los_event, .los_flag,
		.failover_start, .irq);
	irhc_ref_model u_irhc_ref_model (.sys_clk, .ref_clk(ref_clk_in));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xorshift
	task automatic chk(input string nm, input logic [32:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, '0);
	endtask : rd
	task automatic lose(input int i);
		@(posedge sys_clk) los_event[i] <= 1'b1;
		@(posedge sys_clk) los_event[i] <= 1'b0;
	endtask : lose
	// Irq rides along with read data, it is stable by then
	always @(posedge sys_clk)
		if (avs_read && avs_waitrequest === 1'b0)
			chk("read", exp_q.pop_front(), {irq, avs_readdata});
	initial begin
		repeat (100000) @(posedge sys_clk);
		fail_count++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`IRHC_ADDR_CTRL, 33'h0_0000_800a);
		rd(8'h14, '0);
		bus(1'b1, `IRHC_ADDR_MISS_LIM, 32'h0000_0020);
		for (int c = 0; c < 4; c++) begin
			n = c ? 8 << c : 2;
			seed = xorshift(seed);
			bus(1'b1, `IRHC_ADDR_CTRL, 32'h0000_8000 | c << 2);
			lose(0);
			u_irhc_ref_model.burst(0, n - 1, 1 + seed[1:0]);
			rd(`IRHC_ADDR_STATUS, 33'h0_0000_8001);
			chk("los_flag", 2'h1, los_flag);
			u_irhc_ref_model.burst(0, 1, 1 + seed[1:0]);
			rd(`IRHC_ADDR_STATUS, 33'h0_0000_8000);
			chk("los_flag", 2'h0, los_flag);
		end
		bus(1'b1, `IRHC_ADDR_CTRL, 32'h0000_8004);
		lose(0);
		u_irhc_ref_model.burst(0, 10, 1);
		repeat (40) @(posedge sys_clk);
		u_irhc_ref_model.burst(0, 15, 1);
		rd(`IRHC_ADDR_STATUS, 33'h0_0000_8001);
		u_irhc_ref_model.burst(0, 1, 1);
		rd(`IRHC_ADDR_STATUS, 33'h0_0000_8000);
		rd(`IRHC_ADDR_IRQ_STAT, 33'h0_0000_0002);
		bus(1'b1, `IRHC_ADDR_IRQ_MASK, 32'h0000_0002);
		rd(`IRHC_ADDR_IRQ_STAT, 33'h1_0000_0002);
		bus(1'b1, `IRHC_ADDR_IRQ_STAT, 32'h0000_0002);
		rd(`IRHC_ADDR_IRQ_STAT, 33'h0_0000_0000);
		bus(1'b1, `IRHC_ADDR_CTRL, 32'h0000_011c);
		lose(1);
		t = 0;
		while (failover_start !== 1'b1 && t < 70000) begin
			@(posedge sys_clk);
			t++;
		end
		chk("failover", 1, t < 65600);
		rd(`IRHC_ADDR_IRQ_STAT, 33'h0_0000_0001);
		print_verdict();
	end
endmodule : input_revalidation_holdoff_counters_tb_top
